// [rtl/ddc_pkg.sv]
// Overview of operation
// - Leave time code n means (n+1)*16 ms
// - Leave time resets to code 0x07, 128 ms
// - Leave declared after receding target held that long
// - Velocity 3-bit code 0.39..24.80 m/s, reset 0x03
// - Auto rate on: any velocity 0..7 stored
// - Auto rate off: bad velocity pairing rejected, error
// - Rate code 0..4 is 1..16 kHz, reset 1 kHz
// - Stored rate governs only with auto rate off
// - Auto rate on: rate stored despite bad pairing
// - Auto rate off: bad rate pairing discarded, error
// - Noise filter bit, reset enabled, bypass when clear
// - Detect condition: both, approach only, leave only
// - Inversion applied after condition, reset non-inverted
// - PWM frequency code 0..9 is 1..10 kHz, reset 0x04
// - PWM frequency matters only in PWM pin mode
// - Pin mode digital, PWM or UART; reset digital
// - Auto rate picks rate itself; enabled after reset
// - Random channel chosen at startup replaces stored one
package ddc_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PIN_MODE = 8'h83;
  localparam logic [7:0] ADDR_AUTO_RATE_EN = 8'h91;
  localparam logic [7:0] ADDR_RANDOM_CHAN_EN = 8'h92;
  localparam logic [7:0] ADDR_LEAVE_RESPONSE_TIME = 8'h98;
  localparam logic [7:0] ADDR_TARGET_VELOCITY = 8'h99;
  localparam logic [7:0] ADDR_SAMPLING_RATE = 8'h9a;
  localparam logic [7:0] ADDR_NOISE_FILTER_ENABLE = 8'h9b;
  localparam logic [7:0] ADDR_RADIO_CHANNEL_SELECT = 8'h9c;
  localparam logic [7:0] ADDR_OUTPUT_DETECT_CONDITION = 8'ha0;
  localparam logic [7:0] ADDR_OUTPUT_DETECT_INVERT = 8'ha1;
  localparam logic [7:0] ADDR_PWM_FREQUENCY_SELECT = 8'ha3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [6:0] RST_LEAVE_TIME = 7'h07;
  localparam logic [2:0] RST_VELOCITY = 3'h3;
  localparam logic [2:0] RST_RATE = 3'h0;
  localparam logic RST_NOISE = 1'b1;
  localparam logic [3:0] RST_CHANNEL = 4'h5;
  localparam logic [1:0] RST_COND = 2'h0;
  localparam logic RST_INVERT = 1'b0;
  localparam logic [3:0] RST_PWM_FREQ = 4'h4;
  localparam logic [1:0] RST_PIN_MODE = 2'h0;
  localparam logic RST_AUTO_RATE = 1'b1;
  localparam logic RST_RANDOM_CHAN = 1'b1;

  // ----------------------------------------------------------------
  // Field limits and encodings
  // ----------------------------------------------------------------
  localparam int CMD_FLAG_BIT = 7;
  localparam logic [6:0] MAX_VELOCITY = 7'h07;
  localparam logic [6:0] MAX_RATE = 7'h04;
  localparam logic [6:0] MAX_ONE_BIT = 7'h01;
  localparam logic [6:0] MAX_CHANNEL = 7'h09;
  localparam logic [6:0] MAX_COND = 7'h02;
  localparam logic [6:0] MAX_PWM_FREQ = 7'h09;
  localparam logic [6:0] MAX_PIN_MODE = 7'h02;
  localparam logic [3:0] CHANNEL_COUNT = 4'ha;
  localparam logic [3:0] PAIR_SPAN = 4'h3;
  localparam logic [6:0] SENS_HIGH = 7'h32;
  localparam logic [1:0] COND_BOTH = 2'h0;
  localparam logic [1:0] COND_APPROACH = 2'h1;
  localparam logic [1:0] PIN_DIGITAL = 2'h0;
  localparam logic [1:0] PIN_PWM = 2'h1;
  localparam logic [1:0] PIN_UART = 2'h2;
  localparam logic [1:0] RSP_ACK = 2'h0;
  localparam logic [1:0] RSP_READ = 2'h1;
  localparam logic [1:0] RSP_SYNTAX_ERR = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int LEAVE_STEP_MS = 16;
  localparam int CLK_PERIOD_NS = 8;
  localparam int LEAVE_STEP_CYCLES = LEAVE_STEP_MS * 1000000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    CMD_IDLE = 1'b0,
    CMD_HAVE_ADDR = 1'b1
  } ddc_cmd_state_t;

  // Command byte from the host link
  typedef struct packed {
    logic valid;
    logic read;
    logic [7:0] data;
  } ddc_cmd_t;

  // Reply to the host link
  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic [7:0] data;
  } ddc_rsp_t;

  // Settings driven to the rest of the sensor
  typedef struct packed {
    logic [2:0] rate_eff;
    logic noise_filter_on;
    logic [3:0] channel_eff;
    logic [1:0] pin_mode;
    logic pwm_freq_active;
    logic [3:0] pwm_freq;
    logic [2:0] velocity;
    logic leave_detect;
    logic pin_detect;
  } ddc_cfg_t;

  // Velocity and rate pairing check
  function automatic logic ddc_pair_ok(input logic [2:0] vel, input logic [2:0] rate);
    ddc_pair_ok = ({1'b0, vel} <= ({1'b0, rate} + PAIR_SPAN));
  endfunction : ddc_pair_ok

endpackage : ddc_pkg

// [rtl/ddc_hold_timer.sv]
module ddc_hold_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Control
  input wire logic active,
  input wire logic step,
  input wire logic [7:0] limit,
  // Result
  output logic done
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cnt;
    logic done;
  } ddc_hold_state_t;

  ddc_hold_state_t s_r;
  ddc_hold_state_t s_nxt;

  // Counts whole steps of continuous activity, restarts on any gap
  always_comb begin
    s_nxt = s_r;
    if (!active) begin
      s_nxt.cnt = 8'h00;
      s_nxt.done = 1'b0;
    end else begin
      // Saturating step count
      if (step && s_r.cnt != 8'hff) begin
        s_nxt.cnt = s_r.cnt + 8'h01;
      end
      s_nxt.done = (s_nxt.cnt >= limit);
    end
  end

  // Register the state
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done = s_r.done;

endmodule : ddc_hold_timer

// [rtl/ddc_config_regs.sv]
module ddc_config_regs #(
  parameter int LEAVE_STEP_CYCLES = ddc_pkg::LEAVE_STEP_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Host command link
  input wire ddc_pkg::ddc_cmd_t cmd,
  output ddc_pkg::ddc_rsp_t rsp,
  // Detection inputs from signal processing
  input wire logic approach_seen,
  input wire logic receding_seen,
  input wire logic [6:0] sensitivity,
  input wire logic [3:0] random_seed,
  // Settings and detection result
  output ddc_pkg::ddc_cfg_t cfg
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ddc_pkg::ddc_cmd_state_t st;
    logic [7:0] addr;
    logic [6:0] leave_time;
    logic [2:0] velocity;
    logic [2:0] rate;
    logic noise;
    logic [3:0] channel;
    logic [1:0] cond;
    logic invert;
    logic [3:0] pwm_freq;
    logic [1:0] pin_mode;
    logic auto_rate;
    logic random_chan;
    logic seeded;
    logic [3:0] chan_rand;
    logic [20:0] step_cnt;
    ddc_pkg::ddc_rsp_t rsp;
    ddc_pkg::ddc_cfg_t cfg;
  } ddc_state_t;

  ddc_state_t s_r;
  ddc_state_t s_nxt;

  logic leave_step; // One pulse per 16 ms of receding observation
  logic leave_done; // Receding held long enough
  logic [6:0] wval; // Value bits of a parameter byte

  // ----------------------------------------------------------------
  // Leave timer
  // ----------------------------------------------------------------
  // Step pulse restarts with each observation so the time is a minimum
  assign leave_step = (s_r.step_cnt == 21'(LEAVE_STEP_CYCLES - 1));

  ddc_hold_timer u_leave_timer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .active(receding_seen),
    .step(leave_step),
    .limit({1'b0, s_r.leave_time} + 8'h01),
    .done(leave_done)
  );

  assign wval = cmd.data[6:0];

  // ----------------------------------------------------------------
  // Read value by address
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_val(input ddc_state_t s, input logic [7:0] a,
                                          output logic hit);
    hit = 1'b1;
    read_val = 8'h00;
    if (a == ddc_pkg::ADDR_PIN_MODE) begin
      read_val = {6'h00, s.pin_mode};
    end else if (a == ddc_pkg::ADDR_AUTO_RATE_EN) begin
      read_val = {7'h00, s.auto_rate};
    end else if (a == ddc_pkg::ADDR_RANDOM_CHAN_EN) begin
      read_val = {7'h00, s.random_chan};
    end else if (a == ddc_pkg::ADDR_LEAVE_RESPONSE_TIME) begin
      read_val = {1'b0, s.leave_time};
    end else if (a == ddc_pkg::ADDR_TARGET_VELOCITY) begin
      read_val = {5'h00, s.velocity};
    end else if (a == ddc_pkg::ADDR_SAMPLING_RATE) begin
      read_val = {5'h00, s.rate};
    end else if (a == ddc_pkg::ADDR_NOISE_FILTER_ENABLE) begin
      read_val = {7'h00, s.noise};
    end else if (a == ddc_pkg::ADDR_RADIO_CHANNEL_SELECT) begin
      read_val = {4'h0, s.channel};
    end else if (a == ddc_pkg::ADDR_OUTPUT_DETECT_CONDITION) begin
      read_val = {6'h00, s.cond};
    end else if (a == ddc_pkg::ADDR_OUTPUT_DETECT_INVERT) begin
      read_val = {7'h00, s.invert};
    end else if (a == ddc_pkg::ADDR_PWM_FREQUENCY_SELECT) begin
      read_val = {4'h0, s.pwm_freq};
    end else begin
      // Unmapped address
      hit = 1'b0;
    end
  endfunction : read_val

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic ok;
    logic hit;
    logic [7:0] rd;
    logic [2:0] auto_pick;
    logic sel;
    ok = 1'b0;
    hit = 1'b0;
    rd = 8'h00;
    auto_pick = 3'h0;
    sel = 1'b0;
    s_nxt = s_r;
    s_nxt.rsp = '0;

    // Step counter runs only while a receding target is seen
    if (!receding_seen || leave_step) begin
      s_nxt.step_cnt = 21'h0_0000;
    end else begin
      s_nxt.step_cnt = s_r.step_cnt + 21'h0_0001;
    end

    // Catch a random channel once, first cycle after reset release
    if (!s_r.seeded) begin
      s_nxt.seeded = 1'b1;
      if (random_seed >= ddc_pkg::CHANNEL_COUNT) begin
        s_nxt.chan_rand = random_seed - ddc_pkg::CHANNEL_COUNT;
      end else begin
        s_nxt.chan_rand = random_seed;
      end
    end

    // Command bytes
    if (cmd.valid) begin
      if (cmd.data[ddc_pkg::CMD_FLAG_BIT]) begin
        // Address byte
        if (cmd.read) begin
          rd = read_val(s_r, cmd.data, hit);
          s_nxt.rsp.valid = 1'b1;
          s_nxt.rsp.kind = hit ? ddc_pkg::RSP_READ : ddc_pkg::RSP_SYNTAX_ERR;
          s_nxt.rsp.data = rd;
          s_nxt.st = ddc_pkg::CMD_IDLE;
        end else begin
          s_nxt.addr = cmd.data;
          s_nxt.st = ddc_pkg::CMD_HAVE_ADDR;
        end
      end else if (s_r.st == ddc_pkg::CMD_HAVE_ADDR) begin
        // Parameter byte completes a write
        s_nxt.st = ddc_pkg::CMD_IDLE;
        if (s_r.addr == ddc_pkg::ADDR_PIN_MODE) begin
          ok = (wval <= ddc_pkg::MAX_PIN_MODE);
          if (ok) s_nxt.pin_mode = wval[1:0];
        end else if (s_r.addr == ddc_pkg::ADDR_AUTO_RATE_EN) begin
          // Turning auto off needs a legal stored pairing
          ok = (wval <= ddc_pkg::MAX_ONE_BIT) &&
               (wval[0] || ddc_pkg::ddc_pair_ok(s_r.velocity, s_r.rate));
          if (ok) s_nxt.auto_rate = wval[0];
        end else if (s_r.addr == ddc_pkg::ADDR_RANDOM_CHAN_EN) begin
          ok = (wval <= ddc_pkg::MAX_ONE_BIT);
          if (ok) s_nxt.random_chan = wval[0];
        end else if (s_r.addr == ddc_pkg::ADDR_LEAVE_RESPONSE_TIME) begin
          ok = 1'b1;
          s_nxt.leave_time = wval;
        end else if (s_r.addr == ddc_pkg::ADDR_TARGET_VELOCITY) begin
          // Range first, pairing only with auto rate off
          ok = (wval <= ddc_pkg::MAX_VELOCITY) &&
               (s_r.auto_rate ||
                ddc_pkg::ddc_pair_ok(wval[2:0], s_r.rate));
          if (ok) s_nxt.velocity = wval[2:0];
        end else if (s_r.addr == ddc_pkg::ADDR_SAMPLING_RATE) begin
          ok = (wval <= ddc_pkg::MAX_RATE) &&
               (s_r.auto_rate ||
                ddc_pkg::ddc_pair_ok(s_r.velocity, wval[2:0]));
          if (ok) s_nxt.rate = wval[2:0];
        end else if (s_r.addr == ddc_pkg::ADDR_NOISE_FILTER_ENABLE) begin
          ok = (wval <= ddc_pkg::MAX_ONE_BIT);
          if (ok) s_nxt.noise = wval[0];
        end else if (s_r.addr == ddc_pkg::ADDR_RADIO_CHANNEL_SELECT) begin
          ok = (wval <= ddc_pkg::MAX_CHANNEL);
          if (ok) s_nxt.channel = wval[3:0];
        end else if (s_r.addr == ddc_pkg::ADDR_OUTPUT_DETECT_CONDITION) begin
          ok = (wval <= ddc_pkg::MAX_COND);
          if (ok) s_nxt.cond = wval[1:0];
        end else if (s_r.addr == ddc_pkg::ADDR_OUTPUT_DETECT_INVERT) begin
          ok = (wval <= ddc_pkg::MAX_ONE_BIT);
          if (ok) s_nxt.invert = wval[0];
        end else if (s_r.addr == ddc_pkg::ADDR_PWM_FREQUENCY_SELECT) begin
          ok = (wval <= ddc_pkg::MAX_PWM_FREQ);
          if (ok) s_nxt.pwm_freq = wval[3:0];
        end else begin
          // Unmapped address
          ok = 1'b0;
        end
        s_nxt.rsp.valid = 1'b1;
        s_nxt.rsp.kind = ok ? ddc_pkg::RSP_ACK : ddc_pkg::RSP_SYNTAX_ERR;
        s_nxt.rsp.data = s_r.addr;
      end else begin
        // Parameter byte with no address before it
        s_nxt.rsp.valid = 1'b1;
        s_nxt.rsp.kind = ddc_pkg::RSP_SYNTAX_ERR;
        s_nxt.rsp.data = cmd.data;
      end
    end

    // Automatic rate from velocity, one step up for high sensitivity
    if (s_r.velocity > 3'h3) begin
      auto_pick = s_r.velocity - 3'h3;
    end
    if (sensitivity >= ddc_pkg::SENS_HIGH && auto_pick < 3'h4) begin
      auto_pick = auto_pick + 3'h1;
    end
    s_nxt.cfg.rate_eff = s_r.auto_rate ? auto_pick : s_r.rate;

    // Channel in use
    s_nxt.cfg.channel_eff = s_r.random_chan ? s_r.chan_rand : s_r.channel;

    // Plain settings
    s_nxt.cfg.noise_filter_on = s_r.noise;
    s_nxt.cfg.pin_mode = s_r.pin_mode;
    s_nxt.cfg.velocity = s_r.velocity;
    s_nxt.cfg.pwm_freq = s_r.pwm_freq;
    s_nxt.cfg.pwm_freq_active = (s_r.pin_mode == ddc_pkg::PIN_PWM);
    s_nxt.cfg.leave_detect = leave_done;

    // Pin detection: condition, then inversion, digital/PWM only
    case (s_r.cond)
      ddc_pkg::COND_BOTH: sel = approach_seen | leave_done;
      ddc_pkg::COND_APPROACH: sel = approach_seen;
      default: sel = leave_done;
    endcase
    if (s_r.pin_mode == ddc_pkg::PIN_UART) begin
      s_nxt.cfg.pin_detect = 1'b0;
    end else begin
      s_nxt.cfg.pin_detect = sel ^ s_r.invert;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Synchronous reset loads documented defaults
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.st <= ddc_pkg::CMD_IDLE;
      s_r.leave_time <= ddc_pkg::RST_LEAVE_TIME;
      s_r.velocity <= ddc_pkg::RST_VELOCITY;
      s_r.rate <= ddc_pkg::RST_RATE;
      s_r.noise <= ddc_pkg::RST_NOISE;
      s_r.channel <= ddc_pkg::RST_CHANNEL;
      s_r.cond <= ddc_pkg::RST_COND;
      s_r.invert <= ddc_pkg::RST_INVERT;
      s_r.pwm_freq <= ddc_pkg::RST_PWM_FREQ;
      s_r.pin_mode <= ddc_pkg::RST_PIN_MODE;
      s_r.auto_rate <= ddc_pkg::RST_AUTO_RATE;
      s_r.random_chan <= ddc_pkg::RST_RANDOM_CHAN;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rsp = s_r.rsp;
  assign cfg = s_r.cfg;

endmodule : ddc_config_regs

// [bench/ddc_config_regs_monitor.sv]
module ddc_config_regs_monitor #(
  parameter int LEAVE_STEP_CYCLES = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Host link
  input wire ddc_pkg::ddc_cmd_t cmd,
  input wire ddc_pkg::ddc_rsp_t rsp,
  // Detection inputs and settings
  input wire logic approach_seen,
  input wire logic receding_seen,
  input wire logic [6:0] sensitivity,
  input wire logic [3:0] random_seed,
  input wire ddc_pkg::ddc_cfg_t cfg
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic pend_r; // Write address waiting for its value
  logic [1:0] up_r; // Cycles since reset, stops at 3
  int rec_r; // Consecutive cycles with receding target
  // Tracks the pending address, settling time and receding run
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pend_r <= 1'b0;
      up_r <= 2'h0;
      rec_r <= 0;
    end else begin
      if (cmd.valid) begin
        pend_r <= cmd.data[7] && !cmd.read;
      end
      if (up_r != 2'h3) begin
        up_r <= up_r + 2'h1;
      end
      rec_r <= receding_seen ? ((rec_r < 4096) ? rec_r + 1 : rec_r) : 0;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // Command steps
  // ----------------------------------------------------------------
  sequence s_addr_wr;
    cmd.valid && !cmd.read && cmd.data[7];
  endsequence
  sequence s_addr_rd;
    cmd.valid && cmd.read && cmd.data[7];
  endsequence
  sequence s_param;
    cmd.valid && !cmd.data[7];
  endsequence
  sequence s_stray;
    cmd.valid && !cmd.data[7] && !pend_r;
  endsequence
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_WRITE_ANSWER: assert property (s_addr_wr ##1 s_param |=> rsp.valid &&
    rsp.kind != ddc_pkg::RSP_READ && rsp.data == $past(cmd.data, 2))
    else $error("write not answered with its address");
  AST_READ_ANSWER: assert property (s_addr_rd |=> rsp.valid && rsp.kind != ddc_pkg::RSP_ACK)
    else $error("read not answered");
  AST_ADDR_SILENT: assert property (s_addr_wr |=> !rsp.valid)
    else $error("write address answered alone");
  AST_STRAY_ERROR: assert property (s_stray |=> rsp.valid &&
    rsp.kind == ddc_pkg::RSP_SYNTAX_ERR && rsp.data == $past(cmd.data))
    else $error("stray value byte not refused");
  AST_VEL_CHANGE: assert property (up_r == 2'h3 && $changed(cfg.velocity) |->
    $past(rsp.valid) && $past(rsp.kind) == ddc_pkg::RSP_ACK &&
    $past(rsp.data) == ddc_pkg::ADDR_TARGET_VELOCITY)
    else $error("velocity changed without accepted write");
  AST_PWM_ACTIVE: assert property (cfg.pwm_freq_active == (cfg.pin_mode == ddc_pkg::PIN_PWM))
    else $error("pwm frequency active outside pwm mode");
  AST_UART_QUIET: assert property ((cfg.pin_mode == ddc_pkg::PIN_UART) [*3] |-> !cfg.pin_detect)
    else $error("pin detect in uart mode");
  AST_LEAVE_TIME: assert property ($rose(cfg.leave_detect) |-> rec_r >= LEAVE_STEP_CYCLES)
    else $error("leave declared too early");
  AST_LEAVE_DROP: assert property ($fell(receding_seen) |-> ##[1:3] !cfg.leave_detect)
    else $error("leave kept after target gone");
endmodule : ddc_config_regs_monitor

bind ddc_config_regs ddc_config_regs_monitor #(.LEAVE_STEP_CYCLES(LEAVE_STEP_CYCLES))
  ddc_config_regs_monitor_i (.sys_clk(sys_clk), .nrst(nrst), .cmd(cmd), .rsp(rsp),
  .approach_seen(approach_seen), .receding_seen(receding_seen), .sensitivity(sensitivity),
  .random_seed(random_seed), .cfg(cfg));

// [bench/ddc_host_model.sv]
module ddc_host_model (
  // Clock
  input wire logic sys_clk,
  // Command link
  output ddc_pkg::ddc_cmd_t cmd,
  input wire ddc_pkg::ddc_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cmd = '0;
  // Sends one or two bytes, then waits a bounded time for one reply
  task automatic xfer(input logic rd, input logic [7:0] a, input logic two,
                      input logic [6:0] v, output logic [1:0] k, output logic [7:0] d,
                      output logic got);
    got = 1'b0;
    k = 2'h0;
    d = 8'h00;
    @(negedge sys_clk);
    cmd <= '{valid: 1'b1, read: rd, data: a};
    if (two) begin
      @(negedge sys_clk);
      cmd <= '{valid: 1'b1, read: 1'b0, data: {1'b0, v}};
    end
    repeat (4) begin
      @(negedge sys_clk);
      cmd <= '0;
      if (!got && rsp.valid === 1'b1) begin
        got = 1'b1;
        k = rsp.kind;
        d = rsp.data;
      end
    end
  endtask : xfer
endmodule : ddc_host_model

// [bench/ddc_config_regs_bench.sv]
module ddc_config_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------------
  localparam int STEP = 4; // Short leave step
  localparam logic [1:0] K_ACK = ddc_pkg::RSP_ACK;
  localparam logic [1:0] K_RD = ddc_pkg::RSP_READ;
  localparam logic [1:0] K_ERR = ddc_pkg::RSP_SYNTAX_ERR;
  localparam logic [7:0] A_AUTO = 8'h91;
  localparam logic [7:0] A_RAND = 8'h92;
  localparam logic [7:0] A_PIN = 8'h83;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic approach_seen = 1'b0;
  logic receding_seen = 1'b0;
  logic [6:0] sensitivity = 7'h14;
  logic [3:0] random_seed = 4'hd;
  ddc_pkg::ddc_cmd_t cmd;
  ddc_pkg::ddc_rsp_t rsp;
  ddc_pkg::ddc_cfg_t cfg;
  int miscompares = 0;
  int checks_done = 0;
  logic [15:0] lfsr_r = 16'h0001;
  logic [6:0] shadow [8];
  logic [7:0] adr [8] = '{8'h98, 8'h99, 8'h9a, 8'h9b, 8'h9c, 8'ha0, 8'ha1, 8'ha3};
  logic [6:0] rstv [8] = '{7'h07, 7'h03, 7'h00, 7'h01, 7'h05, 7'h00, 7'h00, 7'h04};
  logic [6:0] maxv [8] = '{7'h7f, 7'h07, 7'h04, 7'h01, 7'h09, 7'h02, 7'h01, 7'h09};
  always #4 sys_clk = ~sys_clk;
  ddc_config_regs #(.LEAVE_STEP_CYCLES(STEP)) ddc_config_regs_i (.sys_clk(sys_clk),
    .nrst(nrst), .cmd(cmd), .rsp(rsp), .approach_seen(approach_seen),
    .receding_seen(receding_seen), .sensitivity(sensitivity), .random_seed(random_seed),
    .cfg(cfg));
  ddc_host_model ddc_host_model_i (.sys_clk(sys_clk), .cmd(cmd), .rsp(rsp));
  // ----------------------------------------------------------------
  // Expectations and checks
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  // Rate picked by automatic control
  function automatic logic [7:0] rate_pick(input logic [2:0] v, input logic [6:0] s);
    int a;
    a = (v > 3) ? v - 3 : 0;
    if (s >= 7'h32) begin
      a = a + 1;
    end
    return (a > 4) ? 8'h04 : 8'(a);
  endfunction : rate_pick
  // Pin level for mode n/12, condition (n/4)%3, invert (n/2)%2, approach n%2
  function automatic logic [7:0] det_exp(input int n);
    if (n / 12 == 2) begin
      return 8'h00;
    end
    return 8'((((n / 4) % 3 != 2) && n % 2 == 1) ^ ((n / 2) % 2 == 1));
  endfunction : det_exp
  task automatic cmp(input logic [7:0] g, input logic [7:0] e, input string what);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t %s got %h expected %h", $time, what, g, e);
    end
  endtask : cmp
  // One command with a check of its reply
  task automatic ask(input logic rd, input logic [7:0] a, input logic two, input logic [6:0] v,
                     input logic [1:0] ek, input logic [7:0] ed);
    logic [1:0] k;
    logic [7:0] d;
    logic got;
    ddc_host_model_i.xfer(rd, a, two, v, k, d, got);
    cmp({7'h0, got}, 8'h01, "reply missing");
    cmp({6'h0, k}, {6'h0, ek}, "reply kind");
    cmp(d, ed, "reply data");
  endtask : ask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [6:0] v;
    logic [1:0] ek;
    int i;
    int n;
    repeat (12) @(negedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(negedge sys_clk);
    for (i = 0; i < 8; i++) begin
      ask(1'b1, adr[i], 1'b0, 7'h00, K_RD, {1'b0, rstv[i]});
      shadow[i] = rstv[i];
    end
    cmp(rate_pick(3'h3, sensitivity), {5'h0, cfg.rate_eff}, "auto rate");
    cmp(8'(random_seed % 10), {4'h0, cfg.channel_eff}, "random channel");
    cmp({6'h0, cfg.pin_mode}, 8'h00, "pin mode");
    cmp({7'h0, cfg.pwm_freq_active}, 8'h00, "pwm active");
    ask(1'b1, 8'h80, 1'b0, 7'h00, K_ERR, 8'h00);
    ask(1'b0, 8'h15, 1'b0, 7'h00, K_ERR, 8'h15);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      ask(1'b0, adr[i], 1'b1, maxv[i], K_ACK, adr[i]);
      if (maxv[i] != 7'h7f) begin
        ask(1'b0, adr[i], 1'b1, maxv[i] + 7'h01, K_ERR, adr[i]);
      end
      ask(1'b1, adr[i], 1'b0, 7'h00, K_RD, {1'b0, maxv[i]});
      shadow[i] = maxv[i];
    end
    $display("test range done");
    for (n = 0; n < 40; n++) begin
      lfsr_r = lfsr_next(lfsr_r);
      i = int'(lfsr_r[2:0]);
      v = 7'(lfsr_r[15:8] % (maxv[i] + 2));
      ek = (v <= maxv[i]) ? K_ACK : K_ERR;
      ask(1'b0, adr[i], 1'b1, v, ek, adr[i]);
      if (ek == K_ACK) begin
        shadow[i] = v;
      end
      ask(1'b1, adr[i], 1'b0, 7'h00, K_RD, {1'b0, shadow[i]});
      sensitivity <= 7'(lfsr_r[14:8] % 101);
      repeat (3) @(negedge sys_clk);
      cmp({5'h0, cfg.rate_eff}, rate_pick(shadow[1][2:0], sensitivity), "auto rate");
    end
    $display("test random done");
    sensitivity <= 7'h00;
    ask(1'b0, adr[2], 1'b1, 7'h00, K_ACK, adr[2]);
    ask(1'b0, adr[1], 1'b1, 7'h07, K_ACK, adr[1]);
    ask(1'b0, A_AUTO, 1'b1, 7'h00, K_ERR, A_AUTO);
    ask(1'b0, adr[1], 1'b1, 7'h03, K_ACK, adr[1]);
    ask(1'b0, A_AUTO, 1'b1, 7'h00, K_ACK, A_AUTO);
    ask(1'b0, adr[1], 1'b1, 7'h04, K_ERR, adr[1]);
    ask(1'b1, adr[1], 1'b0, 7'h00, K_RD, 8'h03);
    ask(1'b0, adr[2], 1'b1, 7'h04, K_ACK, adr[2]);
    ask(1'b0, adr[1], 1'b1, 7'h04, K_ACK, adr[1]);
    ask(1'b0, adr[2], 1'b1, 7'h00, K_ERR, adr[2]);
    ask(1'b0, adr[2], 1'b1, 7'h02, K_ACK, adr[2]);
    cmp({5'h0, cfg.rate_eff}, 8'h02, "stored rate");
    ask(1'b0, A_AUTO, 1'b1, 7'h01, K_ACK, A_AUTO);
    ask(1'b0, adr[2], 1'b1, 7'h00, K_ACK, adr[2]);
    cmp({5'h0, cfg.rate_eff}, rate_pick(3'h4, 7'h00), "auto rate");
    $display("test pairing done");
    ask(1'b0, adr[4], 1'b1, 7'h07, K_ACK, adr[4]);
    ask(1'b0, A_RAND, 1'b1, 7'h00, K_ACK, A_RAND);
    cmp({4'h0, cfg.channel_eff}, 8'h07, "stored channel");
    ask(1'b0, adr[3], 1'b1, 7'h00, K_ACK, adr[3]);
    cmp({7'h0, cfg.noise_filter_on}, 8'h00, "noise filter");
    ask(1'b0, adr[7], 1'b1, 7'h09, K_ACK, adr[7]);
    for (i = 0; i < 3; i++) begin
      ask(1'b0, A_PIN, 1'b1, 7'(i), K_ACK, A_PIN);
      cmp({7'h0, cfg.pwm_freq_active}, 8'(i == 1), "pwm active");
      cmp({4'h0, cfg.pwm_freq}, 8'h09, "pwm frequency");
    end
    ask(1'b0, A_PIN, 1'b1, 7'h03, K_ERR, A_PIN);
    for (n = 0; n < 36; n++) begin
      approach_seen <= n[0];
      ask(1'b0, A_PIN, 1'b1, 7'(n / 12), K_ACK, A_PIN);
      ask(1'b0, adr[5], 1'b1, 7'((n / 4) % 3), K_ACK, adr[5]);
      ask(1'b0, adr[6], 1'b1, 7'((n / 2) % 2), K_ACK, adr[6]);
      cmp({7'h0, cfg.pin_detect}, det_exp(n), "pin detect");
    end
    $display("test pin done");
    approach_seen <= 1'b0;
    ask(1'b0, A_PIN, 1'b1, 7'h00, K_ACK, A_PIN);
    ask(1'b0, adr[5], 1'b1, 7'h02, K_ACK, adr[5]);
    ask(1'b0, adr[6], 1'b1, 7'h00, K_ACK, adr[6]);
    for (i = 0; i < 3; i++) begin
      ask(1'b0, adr[0], 1'b1, 7'(i), K_ACK, adr[0]);
      receding_seen <= 1'b1;
      n = 0;
      while (cfg.leave_detect !== 1'b1 && n < 200) begin
        @(negedge sys_clk);
        n++;
      end
      cmp(8'(n >= (i + 1) * STEP && n <= (i + 1) * STEP + 4), 8'h01, "leave delay");
      cmp({7'h0, cfg.pin_detect}, 8'h01, "leave pin");
      receding_seen <= 1'b0;
      repeat (4) @(negedge sys_clk);
      cmp({7'h0, cfg.leave_detect}, 8'h00, "leave drop");
    end
    receding_seen <= 1'b1;
    n = 0;
    repeat (3 * STEP - 2) begin
      @(negedge sys_clk);
      n = n + int'(cfg.leave_detect !== 1'b0);
    end
    receding_seen <= 1'b0;
    repeat (6) begin
      @(negedge sys_clk);
      n = n + int'(cfg.leave_detect !== 1'b0);
    end
    cmp(8'(n), 8'h00, "leave on short run");
    $display("test leave done");
    tally_and_finish();
  end
endmodule : ddc_config_regs_bench
